// file: src/ddrrb_ctl.sv
`timescale 1ns/1ps
module ddrrb_ctl
   import ddrrb_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Link to the memory
   ddrrb_if.ctl lnk
);

   typedef struct packed {
      logic ck;
      ddrrb_lin_t o;
      logic pendV;
      logic [CMD_W-1:0] pendWord;
      logic [5:0] sinceRd;
      logic [5:0] sinceWr;
      logic [5:0] lastHalf;
      logic [LAT_W-1:0] wrWait;
      logic [2:0] wrLeft;
      logic [1:0] wrIdx;
      logic [DQ_W-1:0] rdDq1;
      logic [DQ_W-1:0] rdDq2;
      logic rdV1;
      logic rdV2;
      logic rdF1;
      logic rdF2;
      logic [3:0][DQ_W-1:0] rdBuf;
      logic [1:0] rdIdx;
      logic [7:0] rdBeats;
   } ddrrb_cst_t;

   ddrrb_cst_t q, d;
   logic [31:0] cfg;
   logic [CMD_W-1:0] cmdWord;
   logic cmdPulse;
   logic [3:0][DQ_W-1:0] wrData;
   logic [31:0] status;
   logic [1:0] op;
   logic [1:0] burst;
   logic pre2;
   logic chop;
   logic [MR_W-1:0] cwlEff;
   logic [LAT_W-1:0] wl;
   logic [5:0] sRd;
   logic [5:0] sWr;
   logic rdOk;
   logic wrOk;
   logic [1:0] idx;

   ddrrb_regs u_regs (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .cmdBusy(q.pendV),
      .rdData(q.rdBuf),
      .status(status),
      .cfg(cfg),
      .cmdWord(cmdWord),
      .cmdPulse(cmdPulse),
      .wrData(wrData)
   );

   assign status = {16'h0000, q.rdBeats, 6'h00, (q.wrWait != '0) || (q.wrLeft != '0), q.pendV};

   always_comb begin
      d = q;
      d.rdDq1 = lnk.rdDq;
      d.rdDq2 = q.rdDq1;
      d.rdV1 = lnk.rdValid;
      d.rdV2 = q.rdV1;
      d.rdF1 = lnk.rdFirst;
      d.rdF2 = q.rdF1;
      d.ck = !q.ck;
      if (cmdPulse) begin
         d.pendV = 1'b1;
         d.pendWord = cmdWord;
      end
      op = q.pendWord[CMD_OP_LSB +: 2];
      burst = cfg[CFG_BL_LSB +: 2];
      pre2 = cfg[CFG_PRE2_BIT];
      chop = (burst == BL_FIXED4) || ((burst == BL_OTF) && !q.pendWord[CMD_A12_BIT]);
      cwlEff = cfg[CFG_CWL_LSB +: MR_W];
      if (pre2 && (cwlEff <= CWL_MIN)) begin
         cwlEff = cwlEff + 5'h01;
      end
      wl = LAT_W'(cfg[CFG_AL_LSB +: MR_W]) + LAT_W'(cwlEff);
      if (wl == '0) begin
         wl = 6'h01;
      end
      sRd = (q.sinceRd == SINCE_MAX) ? SINCE_MAX : q.sinceRd + 6'h01;
      sWr = (q.sinceWr == SINCE_MAX) ? SINCE_MAX : q.sinceWr + 6'h01;
      rdOk = (sRd >= CCD_MIN) && !(pre2 && (sRd == RR_FORBID_PRE2))
         && (8'(sWr) >= 8'(cwlEff) + 8'(HALF_BL8) + 8'(WTR_CK));
      wrOk = (8'(sRd) + 8'(cwlEff) >= 8'(cfg[CFG_CL_LSB +: MR_W]) + 8'(q.lastHalf)
         + 8'h01 + (pre2 ? 8'h02 : 8'h01))
         && (q.wrWait == '0) && (q.wrLeft == '0);
      idx = q.rdF2 ? 2'h0 : q.rdIdx;
      // ----------------------------------------------------------------
      // Link clock falling edge: commands and write data change here
      // ----------------------------------------------------------------
      if (q.ck) begin
         d.o.cmd = LC_NOP;
         d.o.burst = burst;
         d.o.pre2 = pre2;
         d.o.cl = cfg[CFG_CL_LSB +: MR_W];
         d.o.cwl = cwlEff;
         d.o.al = cfg[CFG_AL_LSB +: MR_W];
         d.sinceRd = sRd;
         d.sinceWr = sWr;
         if (q.pendV && ((op == OP_ACT) || (op == OP_PRE)
               || ((op == OP_RD) && rdOk) || ((op == OP_WR) && wrOk))) begin
            d.pendV = 1'b0;
            d.o.bg = q.pendWord[CMD_BG_LSB +: 2];
            d.o.bank = q.pendWord[CMD_BANK_LSB +: 2];
            d.o.col = q.pendWord[CMD_COL_LSB +: 2];
            d.o.a10 = q.pendWord[CMD_A10_BIT];
            d.o.a12 = q.pendWord[CMD_A12_BIT];
            unique case (op)
               OP_ACT: d.o.cmd = LC_ACT;
               OP_PRE: d.o.cmd = LC_PRE;
               OP_RD: begin
                  d.o.cmd = LC_RD;
                  d.sinceRd = 6'h00;
                  d.lastHalf = chop ? HALF_BC4 : HALF_BL8;
               end
               OP_WR: begin
                  d.o.cmd = LC_WR;
                  d.sinceWr = 6'h00;
                  d.wrWait = wl;
                  d.wrLeft = chop ? WORDS_BC4 : WORDS_BL8;
                  d.wrIdx = 2'h0;
               end
            endcase
         end
         if ((q.wrWait == 6'h01) || ((q.wrWait == '0) && (q.wrLeft != '0))) begin
            d.wrWait = '0;
            d.o.wrDq = wrData[q.wrIdx];
            d.wrIdx = q.wrIdx + 2'h1;
            d.wrLeft = q.wrLeft - 3'h1;
         end else if (q.wrWait > 6'h01) begin
            d.wrWait = q.wrWait - 6'h01;
         end
         if (q.rdV2) begin
            d.rdBuf[idx] = q.rdDq2;
            d.rdIdx = idx + 2'h1;
            d.rdBeats = q.rdBeats + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{sinceRd: SINCE_MAX, sinceWr: SINCE_MAX, default: '0};
      end else begin
         q <= d;
      end
   end

   assign lnk.ck = q.ck;
   assign lnk.ca = q.o;

endmodule // ddrrb_ctl

// file: src/ddrrb_dev.sv
`timescale 1ns/1ps
module ddrrb_dev
   import ddrrb_pkg::*;
(
   // Link to the controller
   ddrrb_if.dev lnk,
   // Reset
   input wire logic nrst,
   // Bank and burst state
   output logic [NUM_BANKS-1:0] bankOpen,
   output logic burstBusy
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ddrrb_lin_t s1;
      ddrrb_lin_t s2;
      ddrrb_pend_t [LAT_MAX-1:0] pipe;
      ddrrb_pend_t cur;
      logic [1:0] beat;
      logic act;
      logic [MEM_WORDS-1:0][DQ_W-1:0] mem;
      logic [NUM_BANKS-1:0] open;
      logic busy;
      logic [DQ_W-1:0] rdDq;
      logic rdValid;
      logic rdFirst;
      logic dqsPre;
   } ddrrb_dst_t;

   ddrrb_dst_t q, d;

   logic chop;
   logic [LAT_W-1:0] latRd;
   logic [LAT_W-1:0] latWr;
   ddrrb_pend_t newEnt;
   ddrrb_pend_t ent;
   logic [1:0] beat;
   logic emit;
   logic last;
   logic [MEM_AW-1:0] addr;
   logic rdNext1;
   logic rdNext2;

   // ----------------------------------------------------------------
   // Word address of one beat pair inside the addressed bank
   // ----------------------------------------------------------------
   function automatic logic [MEM_AW-1:0] wordAddr(
      input ddrrb_pend_t p,
      input logic [1:0] b
   );
      logic [1:0] w;
      w = p.col + b;
      return {p.bg, p.bank, w};
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;

      // Every link input passes two stages before use
      d.s1 = lnk.ca;
      d.s2 = q.s1;

      // Latency line moves one slot per link clock
      d.pipe = {PEND_IDLE, q.pipe[LAT_MAX-1:1]};
      d.rdValid = 1'b0;
      d.rdFirst = 1'b0;
      d.dqsPre = 1'b0;
      d.busy = 1'b0;

      // Burst length of this command
      unique case (q.s2.burst)
         BL_FIXED8: chop = 1'b0;
         BL_OTF: chop = !q.s2.a12;
         BL_FIXED4: chop = 1'b1;
         default: chop = 1'b0;
      endcase

      latRd = LAT_W'(q.s2.al) + LAT_W'(q.s2.cl);
      latWr = LAT_W'(q.s2.al) + LAT_W'(q.s2.cwl);
      if (latRd == '0) begin
         latRd = 6'h01;
      end
      if (latWr == '0) begin
         latWr = 6'h01;
      end

      newEnt.v = 1'b1;
      newEnt.wr = (q.s2.cmd == LC_WR);
      newEnt.bc4 = chop;
      newEnt.ap = q.s2.a10;
      newEnt.bg = q.s2.bg;
      newEnt.bank = q.s2.bank;
      newEnt.col = q.s2.col;

      // ----------------------------------------------------------------
      // Command decode
      // ----------------------------------------------------------------
      unique case (q.s2.cmd)
         LC_NOP: ;
         LC_ACT: begin
            d.open[{q.s2.bg, q.s2.bank}] = 1'b1;
         end
         LC_PRE: begin
            d.open[{q.s2.bg, q.s2.bank}] = 1'b0;
         end
         LC_RD: begin
            // Burst is queued at its own latency; earlier ones keep going
            d.pipe[latRd - 6'h01] = newEnt;
         end
         LC_WR: begin
            d.pipe[latWr - 6'h01] = newEnt;
         end
         default: ;
      endcase

      // ----------------------------------------------------------------
      // Burst engine: one beat pair per link clock
      // ----------------------------------------------------------------
      emit = 1'b0;
      ent = q.cur;
      beat = q.beat;
      if (q.pipe[0].v) begin
         // A new burst takes over at once, so a read four clocks after
         // an eight-beat one carries on without a gap
         ent = q.pipe[0];
         beat = 2'h0;
         emit = 1'b1;
         d.rdFirst = !q.pipe[0].wr;
      end else if (q.act) begin
         emit = 1'b1;
      end

      last = (beat == (ent.bc4 ? BEAT_LAST_BC4 : BEAT_LAST_BL8));
      addr = wordAddr(ent, beat);

      if (emit) begin
         d.busy = 1'b1;
         d.cur = ent;
         d.beat = beat + 2'h1;
         d.act = !last;
         if (ent.wr) begin
            d.mem[addr] = q.s2.wrDq;
         end else begin
            d.rdDq = q.mem[addr];
            d.rdValid = 1'b1;
         end
         if (last && ent.ap) begin
            // Auto precharge once the final beat is out
            d.open[{ent.bg, ent.bank}] = 1'b0;
         end
         // A plain access leaves the bank open: nothing to do
      end

      // ----------------------------------------------------------------
      // Read preamble: only ahead of a burst that follows an idle bus
      // ----------------------------------------------------------------
      rdNext1 = q.pipe[1].v && !q.pipe[1].wr;
      rdNext2 = q.pipe[2].v && !q.pipe[2].wr && !q.pipe[1].v;
      if (!emit) begin
         d.dqsPre = rdNext1 || (q.s2.pre2 && rdNext2);
      end
      // The long preamble needs two idle clocks, which a spacing of five
      // would not leave; the controller never issues it
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge lnk.ck or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bankOpen = q.open;
   assign burstBusy = q.busy;
   assign lnk.rdDq = q.rdDq;
   assign lnk.rdValid = q.rdValid;
   assign lnk.rdFirst = q.rdFirst;
   assign lnk.dqsPre = q.dqsPre;

endmodule // ddrrb_dev

// file: src/ddrrb_if.sv
`timescale 1ns/1ps
interface ddrrb_if;
   import ddrrb_pkg::*;
   logic ck;
   ddrrb_lin_t ca;
   logic [DQ_W-1:0] rdDq;
   logic rdValid;
   logic rdFirst;
   logic dqsPre;

   modport ctl (
      output ck,
      output ca,
      input rdDq,
      input rdValid,
      input rdFirst,
      input dqsPre
   );

   modport dev (
      input ck,
      input ca,
      output rdDq,
      output rdValid,
      output rdFirst,
      output dqsPre
   );
endinterface

// file: src/ddrrb_pkg.sv
// Overview of operation
// - On-the-fly: A12 low chops, high gives eight
// - Burst field: 00 eight, 01 on-the-fly, 10 chop
// - READ with A10 low keeps bank open
// - READ with A10 high precharges after burst
// - Each on-the-fly READ uses its own A12
// - Eight-beat READs four clocks apart run seamless
// - No READ spacing of five with long preamble
// - On-the-fly WRITE after READ uses own A12
// - Long write preamble raises lowest write latency
// - READ-to-WRITE gap covers latency, burst, preamble
package ddrrb_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int DQ_W = 16;
   localparam int NUM_BANKS = 16;
   localparam int MEM_AW = 6;
   localparam int MEM_WORDS = 64;
   localparam int LAT_W = 6;
   localparam int LAT_MAX = 64;
   localparam int MR_W = 5;
   localparam int CMD_W = 10;

   // ----------------------------------------------------------------
   // Burst modes, beats and timing in link clocks
   // ----------------------------------------------------------------
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [1:0] BEAT_LAST_BL8 = 2'h3;
   localparam logic [1:0] BEAT_LAST_BC4 = 2'h1;
   localparam logic [2:0] WORDS_BL8 = 3'h4;
   localparam logic [2:0] WORDS_BC4 = 3'h2;
   localparam logic [5:0] HALF_BL8 = 6'h04;
   localparam logic [5:0] HALF_BC4 = 6'h02;
   localparam logic [5:0] CCD_MIN = 6'h04;
   localparam logic [5:0] RR_FORBID_PRE2 = 6'h05;
   localparam logic [5:0] WTR_CK = 6'h04;
   localparam logic [5:0] SINCE_MAX = 6'h3F;
   localparam logic [MR_W-1:0] CWL_MIN = 5'h09;

   // ----------------------------------------------------------------
   // Controller registers (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_CFG = 5'h00;
   localparam logic [4:0] REG_CMD = 5'h04;
   localparam logic [4:0] REG_WD_LO = 5'h08;
   localparam logic [4:0] REG_WD_HI = 5'h0C;
   localparam logic [4:0] REG_RD_LO = 5'h10;
   localparam logic [4:0] REG_RD_HI = 5'h14;
   localparam logic [4:0] REG_STAT = 5'h18;
   localparam int CFG_BL_LSB = 0;
   localparam int CFG_PRE2_BIT = 2;
   localparam int CFG_CL_LSB = 8;
   localparam int CFG_CWL_LSB = 16;
   localparam int CFG_AL_LSB = 24;
   localparam logic [31:0] CFG_RST = 32'h0009_0B00;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BG_LSB = 2;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_COL_LSB = 6;
   localparam int CMD_A10_BIT = 8;
   localparam int CMD_A12_BIT = 9;
   localparam logic [1:0] OP_ACT = 2'h0;
   localparam logic [1:0] OP_RD = 2'h1;
   localparam logic [1:0] OP_WR = 2'h2;
   localparam logic [1:0] OP_PRE = 2'h3;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_WRBUSY_BIT = 1;
   localparam int STAT_BEATS_LSB = 8;

   // ----------------------------------------------------------------
   // Link types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LC_NOP = 3'h0,
      LC_ACT = 3'h1,
      LC_RD = 3'h2,
      LC_WR = 3'h3,
      LC_PRE = 3'h4
   } ddrrb_cmd_t;

   typedef struct packed {
      ddrrb_cmd_t cmd;
      logic [1:0] bg;
      logic [1:0] bank;
      logic [1:0] col;
      logic a10;
      logic a12;
      logic [1:0] burst;
      logic pre2;
      logic [MR_W-1:0] cl;
      logic [MR_W-1:0] cwl;
      logic [MR_W-1:0] al;
      logic [DQ_W-1:0] wrDq;
   } ddrrb_lin_t;

   typedef struct packed {
      logic v;
      logic wr;
      logic bc4;
      logic ap;
      logic [1:0] bg;
      logic [1:0] bank;
      logic [1:0] col;
   } ddrrb_pend_t;

   localparam ddrrb_pend_t PEND_IDLE = '0;

endpackage

// file: src/ddrrb_regs.sv
`timescale 1ns/1ps
module ddrrb_regs
   import ddrrb_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Controller side
   input wire logic cmdBusy,
   input wire logic [63:0] rdData,
   input wire logic [31:0] status,
   output logic [31:0] cfg,
   output logic [CMD_W-1:0] cmdWord,
   output logic cmdPulse,
   output logic [3:0][DQ_W-1:0] wrData
);

   typedef struct packed {
      logic waitReq;
      logic [31:0] rdata;
      logic [31:0] cfg;
      logic [CMD_W-1:0] cmdWord;
      logic cmdPulse;
      logic [3:0][DQ_W-1:0] wd;
   } ddrrb_rst_t;

   ddrrb_rst_t q, d;
   logic stall;

   always_comb begin
      d = q;
      d.cmdPulse = 1'b0;
      d.waitReq = 1'b1;
      // Command slot full: hold the master off instead of dropping
      stall = avs_write && (avs_address == REG_CMD) && (cmdBusy || q.cmdPulse);
      if ((avs_read || avs_write) && q.waitReq && !stall) begin
         d.waitReq = 1'b0;
         d.rdata = 32'h0000_0000;
         if (avs_read) begin
            case (avs_address)
               REG_CFG: d.rdata = q.cfg;
               REG_CMD: d.rdata = 32'(q.cmdWord);
               REG_WD_LO: d.rdata = {q.wd[1], q.wd[0]};
               REG_WD_HI: d.rdata = {q.wd[3], q.wd[2]};
               REG_RD_LO: d.rdata = rdData[31:0];
               REG_RD_HI: d.rdata = rdData[63:32];
               REG_STAT: d.rdata = status;
               default: d.rdata = 32'h0000_0000;
            endcase
         end else begin
            case (avs_address)
               REG_CFG: d.cfg = avs_writedata;
               REG_CMD: begin
                  d.cmdWord = avs_writedata[CMD_W-1:0];
                  d.cmdPulse = 1'b1;
               end
               REG_WD_LO: d.wd[1:0] = avs_writedata;
               REG_WD_HI: d.wd[3:2] = avs_writedata;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{waitReq: 1'b1, cfg: CFG_RST, default: '0};
      end else begin
         q <= d;
      end
   end

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.waitReq;
   assign cfg = q.cfg;
   assign cmdWord = q.cmdWord;
   assign cmdPulse = q.cmdPulse;
   assign wrData = q.wd;

endmodule // ddrrb_regs

// file: testbench/ddr_read_burst_control_tb_top.sv
`timescale 1ns/1ps
module ddr_read_burst_control_tb_top
   import ddrrb_pkg::*;
;
   logic ref_clk;
   logic nrst;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_BANKS-1:0] bankOpen;
   logic burstBusy;
   int err_count;
   int comparisons;
   logic [7:0] beats;
   logic [31:0] rd;

   ddrrb_if lnk_if();
   ddrrb_ctl ddrrb_ctl_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk_if));
   ddrrb_dev ddrrb_dev_inst (.lnk(lnk_if), .nrst(nrst), .bankOpen(bankOpen),
      .burstBusy(burstBusy));
   ddrrb_chk ddrrb_chk_inst (.ck(lnk_if.ck), .nrst(nrst), .ca(lnk_if.ca), .rdDq(lnk_if.rdDq),
      .rdValid(lnk_if.rdValid), .rdFirst(lnk_if.rdFirst), .dqsPre(lnk_if.dqsPre));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One edge passes first so a release never meets a new request
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 400);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 400) begin
         err_count++;
         final_report();
      end
   endtask

   task automatic cmd(input logic [1:0] op, input logic [1:0] bg, input logic [1:0] bank,
      input logic a10, input logic a12);
      av(1'b1, REG_CMD, {22'h0, a12, a10, 2'b00, bank, bg, op});
   endtask

   task automatic cfg(input logic pre2, input logic [1:0] burst);
      av(1'b1, REG_CFG, CFG_RST | {29'h0, pre2, burst});
   endtask

   // Bounded poll until link traffic and beat count are done
   task automatic settle();
      int n;
      n = 0;
      do begin
         av(1'b0, REG_STAT, 32'h0000_0000);
         n++;
      end while (n < 80 && (rd[15:8] !== beats || rd[1:0] !== 2'b00));
      chk({24'h0, rd[15:8]}, {24'h0, beats});
      if (rd[15:8] !== beats || rd[1:0] !== 2'b00) begin
         err_count++;
         final_report();
      end
   endtask

   // Bounded wait for bank 6 to close
   task automatic wait_closed();
      int n;
      n = 0;
      while (bankOpen[6] !== 1'b0 && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      if (bankOpen[6] !== 1'b0) begin
         err_count++;
         final_report();
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      av(1'b0, REG_CFG, 32'h0000_0000);
      chk(rd, CFG_RST);
      av(1'b0, 5'h1C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask

   task automatic t_open_read();
      cfg(1'b0, BL_FIXED8);
      cmd(OP_ACT, 2'h1, 2'h2, 1'b0, 1'b0);
      av(1'b1, REG_WD_LO, 32'hA1A1_B0B0);
      av(1'b1, REG_WD_HI, 32'hD3D3_C2C2);
      cmd(OP_WR, 2'h1, 2'h2, 1'b0, 1'b0);
      settle();
      cmd(OP_RD, 2'h1, 2'h2, 1'b0, 1'b0);
      beats += 8'h04;
      settle();
      av(1'b0, REG_RD_LO, 32'h0000_0000);
      chk(rd, 32'hA1A1_B0B0);
      av(1'b0, REG_RD_HI, 32'h0000_0000);
      chk(rd, 32'hD3D3_C2C2);
      chk({31'h0, bankOpen[6]}, 32'h0000_0001);
   endtask

   task automatic t_auto_pre();
      cmd(OP_RD, 2'h1, 2'h2, 1'b1, 1'b1);
      beats += 8'h04;
      settle();
      wait_closed();
      chk({31'h0, bankOpen[6]}, 32'h0000_0000);
      chk({31'h0, burstBusy}, 32'h0000_0000);
   endtask

   task automatic t_fixed_chop();
      cfg(1'b0, BL_FIXED4);
      cmd(OP_ACT, 2'h1, 2'h2, 1'b0, 1'b0);
      cmd(OP_RD, 2'h1, 2'h2, 1'b0, 1'b1);
      beats += 8'h02;
      settle();
      av(1'b0, REG_RD_LO, 32'h0000_0000);
      chk(rd, 32'hA1A1_B0B0);
      chk({31'h0, bankOpen[6]}, 32'h0000_0001);
      cmd(OP_PRE, 2'h1, 2'h2, 1'b0, 1'b0);
      wait_closed();
      chk({31'h0, bankOpen[6]}, 32'h0000_0000);
   endtask

   // Mixed lengths back to back, then a chopped write right behind them
   task automatic t_otf();
      cfg(1'b0, BL_OTF);
      av(1'b1, REG_WD_LO, 32'h5A5A_6B6B);
      av(1'b1, REG_WD_HI, 32'h7C7C_8D8D);
      for (int i = 0; i < 4; i++) begin
         cmd(OP_RD, 2'(i), 2'h0, 1'b0, i[0]);
         beats += i[0] ? 8'h04 : 8'h02;
      end
      cmd(OP_WR, 2'h2, 2'h1, 1'b0, 1'b0);
      settle();
      cmd(OP_RD, 2'h2, 2'h1, 1'b0, 1'b1);
      beats += 8'h04;
      settle();
      av(1'b0, REG_RD_LO, 32'h0000_0000);
      chk(rd, 32'h5A5A_6B6B);
      av(1'b0, REG_RD_HI, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask

   task automatic t_seamless(input logic pre2);
      cfg(pre2, BL_FIXED8);
      for (int i = 0; i < 3; i++) begin
         cmd(OP_RD, 2'(i), 2'h0, 1'b0, 1'b1);
         beats += 8'h04;
      end
      settle();
   endtask

   // ----------------------------------------------------------------
   // Clock and main sequence
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      err_count = 0;
      comparisons = 0;
      beats = 8'h00;
      nrst = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs();
      t_open_read();
      t_auto_pre();
      t_fixed_chop();
      t_otf();
      t_seamless(1'b1);
      t_seamless(1'b0);
      final_report();
   end
endmodule // ddr_read_burst_control_tb_top

// file: testbench/ddrrb_chk.sv
`timescale 1ns/1ps
module ddrrb_chk
   import ddrrb_pkg::*;
(
   // Link signals
   input wire logic ck,
   input wire logic nrst,
   input wire ddrrb_lin_t ca,
   input wire logic [DQ_W-1:0] rdDq,
   input wire logic rdValid,
   input wire logic rdFirst,
   input wire logic dqsPre
);
   default clocking cb @(posedge ck);
   endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // Read history
   // ----------------------------------------------------------------
   logic [5:0] sinceRd_q;
   logic lastBc4_q;
   logic [6:0] need;
   logic rdCmd;
   assign rdCmd = (ca.cmd == LC_RD);
   // Gap floor uses the burst of the last read, not the current mode
   assign need = 7'(ca.cl) + 7'(lastBc4_q ? HALF_BC4 : HALF_BL8) + 7'(ca.pre2 ? 2'h2 : 2'h1) + 7'h01;

   always_ff @(posedge ck or negedge nrst) begin
      if (!nrst) begin
         sinceRd_q <= SINCE_MAX;
         lastBc4_q <= 1'b0;
      end else if (rdCmd) begin
         sinceRd_q <= 6'h01;
         lastBc4_q <= (ca.burst == BL_FIXED4) || (ca.burst == BL_OTF && !ca.a12);
      end else if (sinceRd_q != SINCE_MAX) begin
         sinceRd_q <= sinceRd_q + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_rd_spacing_min: assert property (rdCmd |-> sinceRd_q >= CCD_MIN)
      else $error("read commands closer than four clocks");
   a_no_gap_five: assert property (rdCmd && ca.pre2 |-> sinceRd_q != RR_FORBID_PRE2)
      else $error("read spacing of five with long preamble");
   a_rd_to_wr: assert property (ca.cmd == LC_WR |-> 7'(sinceRd_q) + 7'(ca.cwl) >= need)
      else $error("write too soon after read");
   a_first_valid: assert property (rdFirst |-> rdValid)
      else $error("first beat without valid data");
   a_pre_ends_data: assert property ($fell(dqsPre) |-> rdFirst)
      else $error("preamble not followed by data");
   a_gap_has_pre: assert property (rdFirst && !$past(rdValid) |-> $past(dqsPre))
      else $error("gapped burst without preamble");
   a_long_pre: assert property (rdFirst && ca.pre2 && !$past(rdValid) |-> $past(dqsPre, 2))
      else $error("long preamble too short");
   a_short_pre: assert property (rdFirst && !ca.pre2 && !$past(rdValid) |-> !$past(dqsPre, 2))
      else $error("short preamble too long");
   a_seamless_data: assert property (rdFirst && $past(rdValid) |-> !$past(dqsPre))
      else $error("preamble inside seamless bursts");
   a_bl8_beats: assert property (rdFirst && ca.burst == BL_FIXED8 |-> rdValid [*4])
      else $error("eight beat burst cut short");
   a_bc4_beats: assert property (rdFirst && ca.burst == BL_FIXED4 |-> rdValid [*2] ##1 !rdValid)
      else $error("chopped burst length wrong");
   a_rd_latency: assert property (rdCmd && ca.al == 5'h00 && ca.cl == 5'h0B && sinceRd_q > 6'h10
      |-> ##14 rdFirst)
      else $error("read data not at read latency");
   a_cwl_raised: assert property (ca.pre2 |-> ca.cwl > CWL_MIN)
      else $error("write latency not raised for long preamble");
endmodule // ddrrb_chk
